// file: hdl/label_filter_defines.vh
`ifndef LABEL_FILTER_DEFINES_VH
`define LABEL_FILTER_DEFINES_VH

// Register index within a channel block (address bits 3:2)
`define REG_IDX_DATA      2'h0
`define REG_IDX_CTRL      2'h1
`define REG_IDX_STATUS    2'h2
`define REG_IDX_LABEL     2'h3

// Address field positions
`define ADDR_REG_LSB      2
`define ADDR_REG_MSB      3
`define ADDR_DIR_BIT      4
`define ADDR_CH_LSB       5
`define ADDR_CH_MSB       8

// Receive control bits
`define RXC_LABEL_EN      1
`define RXC_RELOAD        7
`define RXC_RESET         8'h00

// Transmit control bits
`define TXC_LOOPBACK      1
`define TXC_RESET         4'h0

// Transmit status bits
`define TXS_EMPTY         0
`define TXS_LEVEL         1
`define TXS_FULL          2
`define TXS_RESET         3'h1

// Label field of a received word and pointer reload value
`define LABEL_LSB         0
`define LABEL_MSB         7
`define PTR_RESET         1'b0

`endif

// file: hdl/label_mem.v
`timescale 1ns/1ps
`default_nettype none

// Per-channel label store; registered read port for the host and
// a combinational match port for the receiver.
module label_mem #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          clk_sys,
  input  wire          reset,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [7:0]    rd_data,
  input  wire [AW:0]   valid_count,
  input  wire [7:0]    match_label,
  output reg           match_hit
);

  reg [7:0] mem [0:DEPTH-1];
  integer   i;

  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  // Only entries below the write pointer count as programmed
  always @* begin
    match_hit = 1'b0;
    for (i = 0; i < DEPTH; i = i + 1) begin
      if ((i < valid_count) && (mem[i] == match_label)) begin
        match_hit = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: hdl/label_filter_loopback.v
// Summary of operation
// - Tx status bit 0 reads 1 while the Tx FIFO is empty; 1 at reset.
// - Tx status bit 1 reads 1 at or above the configured level; 0 at reset.
// - Tx status bit 2 reads 1 when the Tx FIFO is full; 0 at reset.
// - Label memory addresses come from two counters cleared by Rx control bit 7.
// - Each label write to a non-full memory stores the byte then advances the write pointer.
// - Each label read returns the current entry then advances the read pointer.
// - Receiver compares the low eight label bits against the stored labels.
// - After a reload, only labels written afterwards are matched.
// - Loopback bit routes transmit outputs onto receive inputs internally.
// - Equal channel counts: each Tx channel feeds the same-index Rx channel.
// - Extra Rx channels without a Tx partner are fed from Tx channel 0.
// - Rx control bit 1 enables label comparison; resets to 0.
// - Reload sets both label pointers to zero.
// - Tx control bit 1 selects loopback; resets to 0.
`timescale 1ns/1ps
`default_nettype none
`include "label_filter_defines.vh"

module label_filter_loopback #(
  parameter RXN      = 2,
  parameter TXN      = 1,
  parameter LBL_AW   = 4,
  parameter LBL_SIZE = 16
) (
  input  wire             clk_sys,
  input  wire             reset,
  // Host register port, synchronous, strobes active low
  input  wire             cpu_ren_n,
  input  wire             cpu_wen_n,
  input  wire [8:0]       cpu_add,
  input  wire [7:0]       cpu_din,
  output reg  [7:0]       cpu_dout,
  // Serial lines
  input  wire [TXN-1:0]   tx_line_a,
  input  wire [TXN-1:0]   tx_line_b,
  input  wire [RXN-1:0]   rx_pin_a,
  input  wire [RXN-1:0]   rx_pin_b,
  output reg  [RXN-1:0]   rx_in_a,
  output reg  [RXN-1:0]   rx_in_b,
  // Tx FIFO state from the transmit engines
  input  wire [TXN-1:0]   tx_fifo_empty,
  input  wire [TXN-1:0]   tx_fifo_level,
  input  wire [TXN-1:0]   tx_fifo_full,
  // Received words from the receive engines
  input  wire [RXN-1:0]   rx_word_valid,
  input  wire [RXN*32-1:0] rx_word,
  output reg  [RXN-1:0]   rx_fifo_push,
  output reg  [RXN*32-1:0] rx_fifo_word,
  // Control levels for the serial engines
  output reg  [RXN-1:0]   rx_label_en,
  output reg  [TXN-1:0]   tx_loopback
);

  localparam PW = LBL_AW + 1;
  localparam [PW-1:0] PTR_STEP = {{(PW-1){1'b0}}, 1'b1};

  reg  [7:0]       rx_ctrl_reg  [0:RXN-1];
  reg  [3:0]       tx_ctrl_reg  [0:TXN-1];
  reg  [2:0]       tx_status_reg [0:TXN-1];
  reg  [PW-1:0]    wr_ptr_reg   [0:RXN-1];
  reg  [PW-1:0]    rd_ptr_reg   [0:RXN-1];
  reg              rd_pend_reg;
  reg  [3:0]       rd_ch_reg;
  reg  [1:0]       rd_sel_reg;
  reg              rd_dir_reg;
  reg  [7:0]       rd_reg_data;

  wire [3:0]       ch  = cpu_add[`ADDR_CH_MSB:`ADDR_CH_LSB];
  wire [1:0]       sel = cpu_add[`ADDR_REG_MSB:`ADDR_REG_LSB];
  wire             dir = cpu_add[`ADDR_DIR_BIT];
  wire             wr  = ~cpu_wen_n;
  wire             rd  = ~cpu_ren_n;

  wire [RXN*8-1:0] lbl_rdata;
  wire [RXN-1:0]   lbl_hit;
  integer          k;

  // Decode of a host access to one channel register
  function hit;
    input          acc;
    input          is_tx;
    input integer  want_ch;
    input [1:0]    want_sel;
    begin
      hit = acc && (dir == is_tx) && (ch == want_ch) && (sel == want_sel);
    end
  endfunction

  // Loopback source index for an Rx channel
  function integer loop_src;
    input integer r;
    begin
      if (r < TXN) begin
        loop_src = r;
      end else begin
        loop_src = 0;
      end
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < RXN; g = g + 1) begin : rxch
      wire reload = hit(wr, 1'b0, g, `REG_IDX_CTRL) && cpu_din[`RXC_RELOAD];
      wire lbl_wr = hit(wr, 1'b0, g, `REG_IDX_LABEL);
      wire lbl_rd = hit(rd, 1'b0, g, `REG_IDX_LABEL);

      label_mem #(
        .DEPTH (LBL_SIZE),
        .AW    (LBL_AW)
      ) u_mem (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .wr_en       (lbl_wr && !wr_ptr_reg[g][LBL_AW]),
        .wr_addr     (wr_ptr_reg[g][LBL_AW-1:0]),
        .wr_data     (cpu_din),
        .rd_addr     (rd_ptr_reg[g][LBL_AW-1:0]),
        .rd_data     (lbl_rdata[g*8 +: 8]),
        .valid_count (wr_ptr_reg[g]),
        .match_label (rx_word[g*32+`LABEL_LSB +: `LABEL_MSB+1]),
        .match_hit   (lbl_hit[g])
      );

      always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          rx_ctrl_reg[g] <= `RXC_RESET;
          wr_ptr_reg[g]  <= {PW{`PTR_RESET}};
          rd_ptr_reg[g]  <= {PW{`PTR_RESET}};
        end else begin
          if (hit(wr, 1'b0, g, `REG_IDX_CTRL)) begin
            rx_ctrl_reg[g] <= cpu_din;
          end
          // Reload discards old entries by zeroing the valid count too
          if (reload) begin
            wr_ptr_reg[g] <= {PW{`PTR_RESET}};
            rd_ptr_reg[g] <= {PW{`PTR_RESET}};
          end else begin
            // Write pointer saturates so the memory never wraps over itself
            if (lbl_wr && !wr_ptr_reg[g][LBL_AW]) begin
              wr_ptr_reg[g] <= wr_ptr_reg[g] + PTR_STEP;
            end
            if (lbl_rd) begin
              rd_ptr_reg[g] <= rd_ptr_reg[g] + PTR_STEP;
            end
          end
        end
      end

      always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          rx_label_en[g]            <= 1'b0;
          rx_fifo_push[g]           <= 1'b0;
          rx_fifo_word[g*32 +: 32]  <= 32'h0000_0000;
          rx_in_a[g]                <= 1'b0;
          rx_in_b[g]                <= 1'b0;
        end else begin
          rx_label_en[g] <= rx_ctrl_reg[g][`RXC_LABEL_EN];
          // Unmatched words are dropped while filtering is on
          rx_fifo_push[g] <= rx_word_valid[g] &&
                             (!rx_ctrl_reg[g][`RXC_LABEL_EN] || lbl_hit[g]);
          rx_fifo_word[g*32 +: 32] <= rx_word[g*32 +: 32];
          // Loopback of the mapped transmit channel (loop_src) reroutes this Rx input
          if (tx_loopback[loop_src(g)]) begin
            rx_in_a[g] <= tx_line_a[loop_src(g)];
            rx_in_b[g] <= tx_line_b[loop_src(g)];
          end else begin
            rx_in_a[g] <= rx_pin_a[g];
            rx_in_b[g] <= rx_pin_b[g];
          end
        end
      end
    end

    for (g = 0; g < TXN; g = g + 1) begin : txch
      always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          tx_ctrl_reg[g]   <= `TXC_RESET;
          tx_status_reg[g] <= `TXS_RESET;
          tx_loopback[g]   <= 1'b0;
        end else begin
          if (hit(wr, 1'b1, g, `REG_IDX_CTRL)) begin
            tx_ctrl_reg[g] <= cpu_din[3:0];
          end
          tx_loopback[g] <= tx_ctrl_reg[g][`TXC_LOOPBACK];
          tx_status_reg[g][`TXS_EMPTY] <= tx_fifo_empty[g];
          tx_status_reg[g][`TXS_LEVEL] <= tx_fifo_level[g];
          tx_status_reg[g][`TXS_FULL]  <= tx_fifo_full[g];
        end
      end
    end
  endgenerate

  // Register read mux; label data comes a cycle later from the memory
  always @* begin
    rd_reg_data = 8'h00;
    // Loops keep every array index in range for any channel count
    for (k = 0; k < RXN; k = k + 1) begin
      if (!dir && ch == k && sel == `REG_IDX_CTRL) begin
        rd_reg_data = rx_ctrl_reg[k];
      end
    end
    for (k = 0; k < TXN; k = k + 1) begin
      if (dir && ch == k) begin
        if (sel == `REG_IDX_CTRL) begin
          rd_reg_data = {4'h0, tx_ctrl_reg[k]};
        end else if (sel == `REG_IDX_STATUS) begin
          rd_reg_data = {5'h00, tx_status_reg[k]};
        end
      end
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_pend_reg <= 1'b0;
      rd_ch_reg   <= 4'h0;
      rd_sel_reg  <= 2'h0;
      rd_dir_reg  <= 1'b0;
      cpu_dout    <= 8'h00;
    end else begin
      rd_pend_reg <= rd;
      rd_ch_reg   <= ch;
      rd_sel_reg  <= sel;
      rd_dir_reg  <= dir;
      if (rd && !(!dir && sel == `REG_IDX_LABEL)) begin
        cpu_dout <= rd_reg_data;
      end else if (rd_pend_reg && !rd_dir_reg && rd_sel_reg == `REG_IDX_LABEL) begin
        // Absent channels read as zero
        cpu_dout <= (rd_ch_reg < RXN) ? lbl_rdata[rd_ch_reg*8 +: 8] : 8'h00;
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/lfl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lfl_asserts (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        cpu_ren_n,
  input wire logic        cpu_wen_n,
  input wire logic [8:0]  cpu_add,
  input wire logic [7:0]  cpu_din,
  input wire logic [7:0]  cpu_dout,
  input wire logic [0:0]  tx_line_a,
  input wire logic [1:0]  rx_pin_a,
  input wire logic [1:0]  rx_in_a,
  input wire logic [0:0]  tx_fifo_empty,
  input wire logic [0:0]  tx_fifo_level,
  input wire logic [0:0]  tx_fifo_full,
  input wire logic [1:0]  rx_word_valid,
  input wire logic [63:0] rx_word,
  input wire logic [1:0]  rx_fifo_push,
  input wire logic [63:0] rx_fifo_word,
  input wire logic [1:0]  rx_label_en,
  input wire logic [0:0]  tx_loopback
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire st_rd = !cpu_ren_n && cpu_wen_n && cpu_add[8:2] == 7'h06;
  wire tc_wr = !cpu_wen_n && cpu_add[8:2] == 7'h05;
  wire rc_wr = !cpu_wen_n && cpu_add[8:2] == 7'h01;
  // Flags must be steady, since the status copy lags them by a cycle
  tx_status_read_a: assert property (st_rd && $stable(tx_fifo_empty) && $stable(tx_fifo_level)
    && $stable(tx_fifo_full) |=> cpu_dout == {5'h00, $past(tx_fifo_full), $past(tx_fifo_level),
    $past(tx_fifo_empty)}) else $error("tx status read wrong");
  loop_route_a: assert property (!$past(reset) && $past(tx_loopback[0]) |->
    rx_in_a == {2{$past(tx_line_a[0])}}) else $error("loopback routing wrong");
  pin_route_a: assert property (!$past(reset) && !$past(tx_loopback[0]) |->
    rx_in_a == $past(rx_pin_a)) else $error("pin routing wrong");
  loop_ctrl_a: assert property (tc_wr |-> ##2 tx_loopback[0] == $past(cpu_din[1], 2))
    else $error("loopback bit not applied");
  label_ctrl_a: assert property (rc_wr |-> ##2 rx_label_en[0] == $past(cpu_din[1], 2))
    else $error("label enable not applied");
  pass_all_a: assert property (!$past(reset) && $past(rx_word_valid[0]) && !rx_label_en[0] |->
    rx_fifo_push[0] && rx_fifo_word[31:0] == $past(rx_word[31:0])) else $error("word lost");
  push_cause_a: assert property (rx_fifo_push[0] |-> $past(rx_word_valid[0]))
    else $error("push without word");
  push_data_a: assert property (rx_fifo_push[1] |-> rx_fifo_word[63:32] == $past(rx_word[63:32]))
    else $error("pushed word altered");
endmodule
bind label_filter_loopback lfl_asserts u_chk (.clk_sys(clk_sys), .reset(reset),
  .cpu_ren_n(cpu_ren_n), .cpu_wen_n(cpu_wen_n), .cpu_add(cpu_add), .cpu_din(cpu_din),
  .cpu_dout(cpu_dout), .tx_line_a(tx_line_a), .rx_pin_a(rx_pin_a), .rx_in_a(rx_in_a),
  .tx_fifo_empty(tx_fifo_empty), .tx_fifo_level(tx_fifo_level), .tx_fifo_full(tx_fifo_full),
  .rx_word_valid(rx_word_valid), .rx_word(rx_word), .rx_fifo_push(rx_fifo_push),
  .rx_fifo_word(rx_fifo_word), .rx_label_en(rx_label_en), .tx_loopback(tx_loopback));
`default_nettype wire

// file: tb/cpu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_host_model (
  input  wire logic       clk_sys,
  output logic            cpu_ren_n,
  output logic            cpu_wen_n,
  output logic [8:0]      cpu_add,
  output logic [7:0]      cpu_din,
  input  wire logic [7:0] cpu_dout
);
  initial begin
    cpu_ren_n = 1'b1;
    cpu_wen_n = 1'b1;
    cpu_add = 9'h000;
    cpu_din = 8'h00;
  end
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    cpu_add = a;
    cpu_din = d;
    cpu_wen_n = 1'b0;
    @(posedge clk_sys) #1;
    cpu_wen_n = 1'b1;
    cpu_din = ~d;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk_sys) #1;
    cpu_add = a;
    cpu_ren_n = 1'b0;
    @(posedge clk_sys) #1;
    cpu_ren_n = 1'b1;
    @(posedge clk_sys) #1;
    d = cpu_dout;
  endtask
  // Leaves label compare off so the memory can be accessed safely
  task automatic reload();
    wr(9'h004, 8'h80);
    wr(9'h004, 8'h00);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0, reset = 1'b1, tx_line_a = 1'b0, tx_line_b = 1'b0;
  logic tx_fifo_empty = 1'b1, tx_fifo_level = 1'b0, tx_fifo_full = 1'b0;
  logic [1:0] rx_pin_a = 2'b00, rx_pin_b = 2'b00, rx_word_valid = 2'b00;
  logic [63:0] rx_word = 64'h0;
  wire cpu_ren_n, cpu_wen_n;
  wire [8:0] cpu_add;
  wire [7:0] cpu_din, cpu_dout;
  wire [1:0] rx_in_a, rx_in_b, rx_fifo_push, rx_label_en;
  wire [63:0] rx_fifo_word;
  wire [0:0] tx_loopback;
  logic [7:0] d;
  logic [7:0] lbl [3] = '{8'h11, 8'h22, 8'h33};
  int mismatches = 0, n_tests = 0;
  always #25 clk_sys = ~clk_sys;
  cpu_host_model u_host (.clk_sys(clk_sys), .cpu_ren_n(cpu_ren_n), .cpu_wen_n(cpu_wen_n),
    .cpu_add(cpu_add), .cpu_din(cpu_din), .cpu_dout(cpu_dout));
  label_filter_loopback DUT (.clk_sys(clk_sys), .reset(reset), .cpu_ren_n(cpu_ren_n),
    .cpu_wen_n(cpu_wen_n), .cpu_add(cpu_add), .cpu_din(cpu_din), .cpu_dout(cpu_dout),
    .tx_line_a(tx_line_a), .tx_line_b(tx_line_b), .rx_pin_a(rx_pin_a), .rx_pin_b(rx_pin_b),
    .rx_in_a(rx_in_a), .rx_in_b(rx_in_b), .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_level(tx_fifo_level), .tx_fifo_full(tx_fifo_full), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .rx_fifo_push(rx_fifo_push), .rx_fifo_word(rx_fifo_word),
    .rx_label_en(rx_label_en), .tx_loopback(tx_loopback));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic send(input int c, input logic [31:0] w, input logic e);
    @(posedge clk_sys) #1;
    rx_word[c*32 +: 32] = w;
    rx_word_valid[c] = 1'b1;
    @(posedge clk_sys) #1;
    rx_word_valid[c] = 1'b0;
    chk("push", {7'h00, e}, {7'h00, rx_fifo_push[c]});
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 reset = 1'b0;
    u_host.rd(9'h018, d); chk("tx_status", 8'h01, d);
    tx_fifo_empty = 1'b0;
    tx_fifo_level = 1'b1;
    u_host.rd(9'h018, d); chk("tx_status", 8'h02, d);
    tx_fifo_full = 1'b1;
    u_host.rd(9'h018, d); chk("tx_status", 8'h06, d);
    u_host.reload();
    foreach (lbl[i]) u_host.wr(9'h00c, lbl[i]);
    foreach (lbl[i]) begin
      u_host.rd(9'h00c, d); chk("label", lbl[i], d);
    end
    u_host.reload();
    u_host.rd(9'h00c, d); chk("label", 8'h11, d);
    u_host.wr(9'h00c, 8'h44);
    u_host.wr(9'h004, 8'h02);
    send(0, 32'h0000_0144, 1'b1);
    send(0, 32'h0000_0022, 1'b0);
    send(0, 32'h0000_0055, 1'b0);
    send(1, 32'h0000_0066, 1'b1);
    u_host.wr(9'h004, 8'h00);
    send(0, 32'h0000_0055, 1'b1);
    tx_line_a = 1'b1;
    rx_pin_b = 2'b11;
    u_host.wr(9'h014, 8'h02);
    u_host.rd(9'h014, d); chk("tx_ctrl", 8'h02, d);
    u_host.rd(9'h074, d); chk("far_ch", 8'h00, d);
    chk("rx_in_a", 8'h03, {6'h00, rx_in_a});
    chk("rx_in_b", 8'h00, {6'h00, rx_in_b});
    u_host.wr(9'h014, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk("rx_in_b", 8'h03, {6'h00, rx_in_b});
    final_report();
  end
endmodule
`default_nettype wire
